// file: verilog/split_timer_defs.svh
`ifndef SPLIT_TIMER_DEFS_SVH
`define SPLIT_TIMER_DEFS_SVH

// Special-function bus addresses of the timer registers.
`define TMR_ADDR_CONTROL 8'hB9
`define TMR_ADDR_RELOAD_LOW 8'hBA
`define TMR_ADDR_RELOAD_HIGH 8'hBB
`define TMR_ADDR_COUNT_LOW 8'hBC
`define TMR_ADDR_COUNT_HIGH 8'hBD

// Bit positions inside the control register.
`define TMR_BIT_HIGH_FLAG 7
`define TMR_BIT_LOW_FLAG 6
`define TMR_BIT_LOW_IRQ_EN 5
`define TMR_BIT_SPLIT 4
`define TMR_BIT_HIGH_CAP 3
`define TMR_BIT_LOW_CAP 2
`define TMR_BIT_HIGH_RUN 1
`define TMR_BIT_LOW_RUN 0

// Reset values.
`define TMR_RESET_CONTROL 8'h00
`define TMR_RESET_BYTE 8'h00
`define TMR_UNMAPPED_READ 8'h00

// Width of one counter half.
`define TMR_HALF_WIDTH 8

`endif

// file: verilog/split_timer_pkg.sv
package split_timer_pkg;

   typedef struct packed {
      logic high_half_flag;
      logic low_half_flag;
      logic low_flag_irq_enable;
      logic split_select;
      logic high_capture_select;
      logic low_capture_select;
      logic high_run_enable;
      logic low_run_enable;
   } control_type;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } sfr_req_type;

   typedef struct packed {
      control_type control;
      logic [7:0] reload_low_byte;
      logic [7:0] reload_high_byte;
      logic [7:0] count_low_byte;
      logic [7:0] count_high_byte;
      logic [7:0] rdata;
      logic irq;
   } timer_state_type;

endpackage : split_timer_pkg

// file: verilog/timer_half.sv
`timescale 1ns/1ps
`default_nettype none

// One counter half: counts, reloads on wrap in timer mode, captures in capture mode.
module timer_half #(
   parameter int WIDTH = 8
) (
   // Present state
   input wire logic [WIDTH-1:0] count,
   input wire logic [WIDTH-1:0] reload,
   // Controls
   input wire logic inc,
   input wire logic load_on_wrap,
   input wire logic cap_mode,
   input wire logic capture,
   // Next state
   output logic [WIDTH-1:0] count_next,
   output logic [WIDTH-1:0] reload_next,
   output logic wrap
);

   always_comb begin
      wrap = inc && (count == {WIDTH{1'b1}});
      count_next = count;
      if (inc) begin
         count_next = count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
      if (wrap && load_on_wrap && !cap_mode) begin
         count_next = reload;
      end
      reload_next = reload;
      if (cap_mode && capture) begin
         reload_next = count;
      end
   end

endmodule : timer_half

`default_nettype wire

// file: verilog/split_capture_timer_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "split_timer_defs.svh"

module split_capture_timer_control #(
   parameter int HALF_WIDTH = `TMR_HALF_WIDTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Special-function register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Timer events
   input wire logic count_tick,
   input wire logic capture_strobe,
   // Interrupt request
   output logic timer_irq
);

   ////////////////////////////////////////////////////////////////////////////////////

   // The register map is byte wide; other half widths would need a new map.
   generate
      if (HALF_WIDTH != 8) begin : g_width_check
         $error("HALF_WIDTH must be 8");
      end
   endgenerate

   function automatic logic [7:0] read_mux(input split_timer_pkg::timer_state_type s,
                                           input logic [7:0] addr);
      case (addr)
         `TMR_ADDR_CONTROL: read_mux = s.control;
         `TMR_ADDR_RELOAD_LOW: read_mux = s.reload_low_byte;
         `TMR_ADDR_RELOAD_HIGH: read_mux = s.reload_high_byte;
         `TMR_ADDR_COUNT_LOW: read_mux = s.count_low_byte;
         `TMR_ADDR_COUNT_HIGH: read_mux = s.count_high_byte;
         default: read_mux = `TMR_UNMAPPED_READ;
      endcase
   endfunction : read_mux

   split_timer_pkg::timer_state_type state_reg;
   split_timer_pkg::timer_state_type state_next;
   split_timer_pkg::sfr_req_type req;

   logic split_mode;
   logic low_cap_mode;
   logic high_cap_mode;
   logic low_inc;
   logic high_inc;
   logic low_wrap;
   logic high_wrap;
   logic set_high_flag;
   logic set_low_flag;
   logic [7:0] low_count_hw;
   logic [7:0] high_count_hw;
   logic [7:0] low_reload_hw;
   logic [7:0] high_reload_hw;

   assign req = '{addr: sfr_addr, wr: sfr_wr, rd: sfr_rd, wdata: sfr_wdata};

   ////////////////////////////////////////////////////////////////////////////////////

   always_comb begin
      split_mode = state_reg.control.split_select;
      low_cap_mode = state_reg.control.low_capture_select;
      // In wide mode the high half follows the low half's controls.
      high_cap_mode = split_mode ? state_reg.control.high_capture_select
                                 : state_reg.control.low_capture_select;
      low_inc = count_tick && state_reg.control.low_run_enable;
   end

   // The wide carry comes back out of the low half, so it is formed apart from the block that
   // feeds that half; one shared block would read as a loop.
   always_comb begin
      if (split_mode) begin
         high_inc = count_tick && state_reg.control.high_run_enable;
      end else begin
         high_inc = low_wrap;
      end
   end

   timer_half #(
      .WIDTH(HALF_WIDTH)
   ) u_low_half (
      .count(state_reg.count_low_byte),
      .reload(state_reg.reload_low_byte),
      .inc(low_inc),
      .load_on_wrap(split_mode),
      .cap_mode(low_cap_mode),
      .capture(capture_strobe),
      .count_next(low_count_hw),
      .reload_next(low_reload_hw),
      .wrap(low_wrap)
   );

   // In wide timer mode the low byte reloads together with the high byte on a 16-bit wrap.
   logic [7:0] low_count_final;
   always_comb begin
      low_count_final = low_count_hw;
      if (!split_mode && !low_cap_mode && high_wrap) begin
         low_count_final = state_reg.reload_low_byte;
      end
   end

   timer_half #(
      .WIDTH(HALF_WIDTH)
   ) u_high_half (
      .count(state_reg.count_high_byte),
      .reload(state_reg.reload_high_byte),
      .inc(high_inc),
      .load_on_wrap(1'b1),
      .cap_mode(high_cap_mode),
      .capture(capture_strobe),
      .count_next(high_count_hw),
      .reload_next(high_reload_hw),
      .wrap(high_wrap)
   );

   ////////////////////////////////////////////////////////////////////////////////////

   always_comb begin
      if (split_mode) begin
         set_high_flag = high_wrap || (high_cap_mode && capture_strobe);
         set_low_flag = low_cap_mode ? capture_strobe : low_wrap;
      end else if (low_cap_mode) begin
         set_high_flag = capture_strobe;
         set_low_flag = high_wrap;
      end else begin
         set_high_flag = high_wrap;
         set_low_flag = low_wrap;
      end
   end

   always_comb begin
      state_next = state_reg;
      // Control and reload writes act first so that a hardware update in the same cycle wins.
      if (req.wr) begin
         case (req.addr)
            `TMR_ADDR_CONTROL: state_next.control = req.wdata;
            `TMR_ADDR_RELOAD_LOW: state_next.reload_low_byte = req.wdata;
            `TMR_ADDR_RELOAD_HIGH: state_next.reload_high_byte = req.wdata;
            default: ;
         endcase
      end
      // A capture beats a same-cycle reload write, even when the captured count equals the old byte.
      if (low_cap_mode && capture_strobe) begin
         state_next.reload_low_byte = low_reload_hw;
      end
      if (high_cap_mode && capture_strobe) begin
         state_next.reload_high_byte = high_reload_hw;
      end
      state_next.count_low_byte = low_count_final;
      state_next.count_high_byte = high_count_hw;
      // A software count write overrides the counting step of that cycle.
      if (req.wr && req.addr == `TMR_ADDR_COUNT_LOW) begin
         state_next.count_low_byte = req.wdata;
      end
      if (req.wr && req.addr == `TMR_ADDR_COUNT_HIGH) begin
         state_next.count_high_byte = req.wdata;
      end
      if (set_high_flag) begin
         state_next.control.high_half_flag = 1'b1;
      end
      if (set_low_flag) begin
         state_next.control.low_half_flag = 1'b1;
      end
      state_next.irq = state_next.control.high_half_flag ||
                       (state_next.control.low_half_flag &&
                        state_next.control.low_flag_irq_enable);
      state_next.rdata = req.rd ? read_mux(state_reg, req.addr) : state_reg.rdata;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg.control <= `TMR_RESET_CONTROL;
         state_reg.reload_low_byte <= `TMR_RESET_BYTE;
         state_reg.reload_high_byte <= `TMR_RESET_BYTE;
         state_reg.count_low_byte <= `TMR_RESET_BYTE;
         state_reg.count_high_byte <= `TMR_RESET_BYTE;
         state_reg.rdata <= `TMR_UNMAPPED_READ;
         state_reg.irq <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign sfr_rdata = state_reg.rdata;
   assign timer_irq = state_reg.irq;

   ////////////////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_high_flag_sticky: assert property (
      $past(state_reg.control.high_half_flag) && !$past(sfr_wr) |-> state_reg.control.high_half_flag)
      else $error("high flag dropped without a write");

   a_low_flag_sticky: assert property (
      $past(state_reg.control.low_half_flag) && !$past(sfr_wr) |-> state_reg.control.low_half_flag)
      else $error("low flag dropped without a write");

   a_wide_low_wrap: assert property (
      !split_mode && !low_cap_mode && low_inc && state_reg.count_low_byte == 8'hFF
      |=> state_reg.control.low_half_flag)
      else $error("wide low overflow did not set low flag");

   a_wide_cap_carry: assert property (
      !split_mode && low_cap_mode && high_wrap |=> state_reg.control.low_half_flag)
      else $error("wide capture wrap did not set low flag");

   a_wide_cap_only_high: assert property (
      !split_mode && low_cap_mode && capture_strobe && !low_wrap && !sfr_wr
      && !state_reg.control.low_half_flag
      |=> state_reg.control.high_half_flag && !state_reg.control.low_half_flag)
      else $error("wide capture flag routing wrong");

   a_irq_formula: assert property (
      ##1 timer_irq == (state_reg.control.high_half_flag ||
      (state_reg.control.low_half_flag && state_reg.control.low_flag_irq_enable)))
      else $error("interrupt request does not match flags");

   a_wide_high_hold: assert property (
      !split_mode && !low_wrap && !sfr_wr |=> $stable(state_reg.count_high_byte))
      else $error("wide high byte moved without carry");

   a_split_high_inc: assert property (
      split_mode && high_inc && state_reg.count_high_byte != 8'hFF && !sfr_wr
      |=> state_reg.count_high_byte == $past(state_reg.count_high_byte) + 8'h01)
      else $error("split high half did not count");

   a_capture_value: assert property (
      split_mode && low_cap_mode && capture_strobe
      |=> state_reg.reload_low_byte == $past(state_reg.count_low_byte))
      else $error("capture value not stored");

   a_set_beats_clear: assert property (
      set_low_flag |=> state_reg.control.low_half_flag)
      else $error("low flag set lost");

   c_wide_timer_wrap: cover property (!split_mode && !low_cap_mode && high_wrap);
   c_wide_capture: cover property (!split_mode && low_cap_mode && capture_strobe);
   c_split_both_wrap: cover property (split_mode && low_wrap && high_wrap);
   c_irq_rise: cover property ($rose(timer_irq));

endmodule : split_capture_timer_control

`default_nettype wire

// file: test/test_split_capture_timer_control.sv
`timescale 1ns/1ps
`default_nettype none

module test_split_capture_timer_control;
   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] rl;
      logic [7:0] rh;
      logic [7:0] cl;
      logic [7:0] ch;
   } model_type;

   logic clk, rst, sfr_wr, sfr_rd, count_tick, capture_strobe, timer_irq;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, exp_rd;
   logic [31:0] seed;
   model_type m;
   int failures, checked, cycles;
   logic [7:0] modes [10] = '{8'h01, 8'h05, 8'h0D, 8'h25, 8'h02, 8'h0A, 8'h13, 8'h17, 8'h1B, 8'h32};

   split_capture_timer_control DUT (.clk(clk), .rst(rst), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .count_tick(count_tick), .capture_strobe(capture_strobe), .timer_irq(timer_irq));

////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction : xs

   function automatic logic [7:0] rd_fn(input model_type s, input logic [7:0] a);
      case (a)
         8'hB9: return s.ctl;
         8'hBA: return s.rl;
         8'hBB: return s.rh;
         8'hBC: return s.cl;
         8'hBD: return s.ch;
         default: return 8'h00;
      endcase
   endfunction : rd_fn

   // Hardware flag sets are gathered apart so that a same-cycle software write cannot hide them.
   function automatic model_type step(input model_type s, input logic [7:0] a, input logic w,
      input logic [7:0] d, input logic t, input logic c);
      model_type n;
      logic [1:0] hs;
      logic [16:0] sum;
      n = s;
      hs = 2'b00;
      sum = {1'b0, s.ch, s.cl} + 17'h0_0001;
      if (t && !s.ctl[4] && s.ctl[0]) begin
         {n.ch, n.cl} = sum[15:0];
         if (!s.ctl[2] && s.cl == 8'hFF) hs[0] = 1'b1;
         if (sum[16] && s.ctl[2]) hs[0] = 1'b1;
         if (sum[16] && !s.ctl[2]) begin
            hs[1] = 1'b1;
            {n.ch, n.cl} = {s.rh, s.rl};
         end
      end
      if (t && s.ctl[4] && s.ctl[0]) begin
         n.cl = s.cl + 8'h01;
         if (s.cl == 8'hFF && !s.ctl[2]) begin
            hs[0] = 1'b1;
            n.cl = s.rl;
         end
      end
      if (t && s.ctl[4] && s.ctl[1]) begin
         n.ch = s.ch + 8'h01;
         if (s.ch == 8'hFF) hs[1] = 1'b1;
         if (s.ch == 8'hFF && !s.ctl[3]) n.ch = s.rh;
      end
      // Writes come after the count step but before captures: a capture beats a reload write.
      if (w) begin
         case (a)
            8'hB9: n.ctl = d;
            8'hBA: n.rl = d;
            8'hBB: n.rh = d;
            8'hBC: n.cl = d;
            8'hBD: n.ch = d;
            default: ;
         endcase
      end
      if (c && s.ctl[2]) begin
         n.rl = s.cl;
         if (!s.ctl[4]) begin
            n.rh = s.ch;
            hs[1] = 1'b1;
         end else begin
            hs[0] = 1'b1;
         end
      end
      if (c && s.ctl[4] && s.ctl[3]) begin
         n.rh = s.ch;
         hs[1] = 1'b1;
      end
      n.ctl[7:6] = n.ctl[7:6] | hs;
      return n;
   endfunction : step

////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (rst) begin
         m = '0;
         exp_rd = 8'h00;
      end else begin
         if (sfr_rd) exp_rd = rd_fn(m, sfr_addr);
         m = step(m, sfr_addr, sfr_wr, sfr_wdata, count_tick, capture_strobe);
      end
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
   end

////////////////////////////////////////////////////////////////////////////////
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t read data %h expected %h", $time, got, exp);
      end
   endtask : cmp_byte

   task automatic cmp_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t interrupt %b expected %b", $time, got, exp);
      end
   endtask : cmp_bit

   task automatic cycle(input logic [7:0] a, input logic w, input logic r, input logic [7:0] d,
      input logic t, input logic c);
      @(negedge clk);
      cmp_byte(sfr_rdata, exp_rd);
      cmp_bit(timer_irq, m.ctl[7] | (m.ctl[6] & m.ctl[5]));
      sfr_addr = a;
      sfr_wr = w;
      sfr_rd = r;
      sfr_wdata = d;
      count_tick = t;
      capture_strobe = c;
   endtask : cycle

   task automatic scen(input logic [7:0] mode);
      cycle(8'hB9, 1'b1, 1'b0, mode, 1'b0, 1'b0);
      cycle(8'hBC, 1'b1, 1'b0, 8'hFF, 1'b0, 1'b0);
      cycle(8'hBD, 1'b1, 1'b0, 8'hFF, 1'b0, 1'b0);
      cycle(8'hBA, 1'b1, 1'b0, 8'h34, 1'b0, 1'b0);
      cycle(8'hBB, 1'b1, 1'b0, 8'h12, 1'b0, 1'b0);
      cycle(8'hB9, 1'b1, 1'b0, mode, 1'b1, 1'b0);
      cycle(8'hBC, 1'b1, 1'b1, 8'h77, 1'b1, 1'b0);
      cycle(8'hB9, 1'b1, 1'b0, mode, 1'b0, 1'b0);
      cycle(8'h00, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1);
      cycle(8'hBA, 1'b1, 1'b0, 8'h55, 1'b0, 1'b1);
      for (int a = 8'hB9; a <= 8'hBE; a++) cycle(a[7:0], 1'b0, 1'b1, 8'h00, 1'b0, 1'b0);
   endtask : scen

   task automatic final_report();
      if (failures == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : final_report

////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      {sfr_addr, sfr_wr, sfr_rd, sfr_wdata, count_tick, capture_strobe} = '0;
      failures = 0;
      checked = 0;
      cycles = 0;
      seed = 32'h0000_C672;
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      foreach (modes[i]) scen(modes[i]);
      // Ticks and captures never share a cycle here, so capture timing stays unambiguous.
      for (int i = 0; i < 3000; i++) begin
         seed = xs(seed);
         cycle(8'hB8 + {5'b0, seed[10:8]}, seed[2:0] == 3'd3, seed[2:1] == 2'd2,
            seed[23:16], seed[2:1] == 2'd0, seed[2:0] == 3'd2);
         if (i == 1500) begin
            rst = 1'b1;
            cycle(8'h00, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
            cycle(8'h00, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
            rst = 1'b0;
         end
      end
      final_report();
   end
endmodule : test_split_capture_timer_control

`default_nettype wire
